// ==== core/cft_cfg.svh ====
// Register map, field positions, reset values and interrupt bits of the filter and send control block
//
// Summary of operation
// - Each filter has one enable bit; a disabled filter never takes part in matching.
// - Two-bit mask choice per filter selects acceptance mask 0 to 3.
// - Five-bit destination per filter names the storing queue, value equals queue index.
// - Four filters per word in byte lanes: enable top, mask choice, destination low.
// - Mask choice and destination change only while that filter's enable is clear.
// - Abandoned flag: 1 after an abort, 0 after success or queue reset.
// - Arbitration loss flag sets when this queue's message loses arbitration.
// - Send fault flag sets when a bus error hits this queue's message.
// - Arbitration loss and fault flags clear on a control read or queue reset.
// - Software sets send request; hardware clears it once all queued messages are sent.
// - Writing 0 to a set send request asks to abort the pending message.
// - A receive queue ignores its send request bit entirely.
// - Auto remote reply enabled: a received remote request sets the send request.
// - Two-bit send priority ranks pending queues, 11 highest, 00 lowest.
// - Queue configuration fields are writable only while operating mode equals 100.
// - Thirty-two queues, each with an identical control register.
`ifndef CFT_CFG_SVH
`define CFT_CFG_SVH

`define CFT_ADDR_MODE      12'h000
`define CFT_ADDR_STAT      12'h004
`define CFT_ADDR_MASK      12'h008
`define CFT_ADDR_FLT_BASE  12'h040
`define CFT_ADDR_FIFO_BASE 12'h080

`define CFT_MODE_LSB       21
`define CFT_MODE_CONFIG    3'b100
`define CFT_MODE_RST       3'b100

`define CFT_LANE_W         8
`define CFT_LANE_EN        7
`define CFT_LANE_MSEL_LSB  5
`define CFT_LANE_DEST_LSB  0
`define CFT_FLT_RST        32'h0000_0000

`define CFT_Q_DIR          7
`define CFT_Q_ABANDON      6
`define CFT_Q_ARB          5
`define CFT_Q_FAULT        4
`define CFT_Q_REQ          3
`define CFT_Q_AUTO         2
`define CFT_Q_PRIO_LSB     0

`define CFT_IRQ_W          6
`define CFT_IRQ_RX_STORE   0
`define CFT_IRQ_RX_DROP    1
`define CFT_IRQ_TX_SENT    2
`define CFT_IRQ_TX_ABORT   3
`define CFT_IRQ_ARB        4
`define CFT_IRQ_FAULT      5

`endif

// ==== core/cft_filter_tx_ctrl.sv ====
// Acceptance filter configuration and per-queue send control behind an AHB-Lite slave
`include "cft_cfg.svh"
module cft_filter_tx_ctrl #(
    parameter int NUM_FLT_REGS = 8,
    parameter int NUM_QUEUES   = 32
) (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    input  wire logic                      rx_valid,
    input  wire logic [4*NUM_FLT_REGS-1:0] rx_hit,
    input  wire logic                      rtr_rx,
    input  wire logic [4:0]                rtr_queue,
    input  wire logic [4:0]                evt_queue,
    input  wire logic                      evt_sent,
    input  wire logic                      evt_last,
    input  wire logic                      evt_aborted,
    input  wire logic                      evt_arb_lost,
    input  wire logic                      evt_bus_err,
    input  wire logic                      queue_reset,
    output logic                           rx_store,
    output logic                           rx_drop,
    output logic      [4:0]                rx_queue,
    output logic      [1:0]                rx_mask,
    output logic      [4*NUM_FLT_REGS-1:0] filter_on_flag,
    output logic      [8*NUM_FLT_REGS-1:0] mask_choice,
    output logic                           tx_pending,
    output logic      [4:0]                tx_queue,
    output logic                           tx_abort,
    output logic      [2:0]                operating_mode_field,
    output logic                           irq
);
    import cft_pkg::*;

    localparam int NF = 4 * NUM_FLT_REGS;
    localparam int NQ = NUM_QUEUES;
    logic [31:0]          flt_ff [NUM_FLT_REGS];
    logic [31:0]          nxt_flt [NUM_FLT_REGS];
    logic [NQ-1:0]        req_ff, abort_ff, abandon_ff, arb_ff, fault_ff, auto_ff, dir_ff;
    logic [NQ-1:0]        nxt_req, nxt_abort, nxt_abandon, nxt_arb, nxt_fault, nxt_auto, nxt_dir;
    logic [1:0]           prio_ff [NQ];
    logic [1:0]           nxt_prio [NQ];
    logic [2:0]           mode_ff, nxt_mode;
    logic [`CFT_IRQ_W-1:0] stat_ff, nxt_stat, mask_ff, nxt_mask;
    logic                 irq_ff, nxt_irq;
    logic                 wr_pend_ff, nxt_wr_pend;
    logic [11:0]          wr_addr_ff, nxt_wr_addr;
    logic [31:0]          hrdata_ff, nxt_hrdata;
    logic                 hreadyout_ff;
    logic                 rx_store_ff, nxt_rx_store, rx_drop_ff, nxt_rx_drop;
    logic [4:0]           rx_queue_ff, nxt_rx_queue;
    logic [1:0]           rx_mask_ff, nxt_rx_mask;
    logic                 tx_pending_ff, nxt_tx_pending, tx_abort_ff, nxt_tx_abort;
    logic [4:0]           tx_queue_ff, nxt_tx_queue;
    logic                 rd_take;
    cft_reg_kind_type     rd_kind, wr_kind;
    logic [4:0]           rd_idx, wr_idx;
    logic [NF-1:0]        flt_en;
    logic [NF-1:0]        live_hit;

    // Register decode shared by the read and write paths
    function automatic cft_reg_kind_type decode(input logic [11:0] a);
        if (a == `CFT_ADDR_MODE) begin
            return CFT_K_MODE;
        end else if (a == `CFT_ADDR_STAT) begin
            return CFT_K_STAT;
        end else if (a == `CFT_ADDR_MASK) begin
            return CFT_K_MASK;
        end else if (a[11:7] == `CFT_ADDR_FIFO_BASE >> 7 && a[1:0] == 2'b00) begin
            return CFT_K_FIFO;
        end else if (a[11:5] == `CFT_ADDR_FLT_BASE >> 5 && a[1:0] == 2'b00
                     && int'(a[4:2]) < NUM_FLT_REGS) begin
            return CFT_K_FLT;
        end
        return CFT_K_NONE;
    endfunction : decode

    // Lowest set bit of a filter hit vector
    function automatic logic [4:0] lowest_index(input logic [NF-1:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = NF - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction : lowest_index

    function automatic logic [31:0] queue_word(input int n);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`CFT_Q_DIR]                       = dir_ff[n];
        w[`CFT_Q_ABANDON]                   = abandon_ff[n];
        w[`CFT_Q_ARB]                       = arb_ff[n];
        w[`CFT_Q_FAULT]                     = fault_ff[n];
        w[`CFT_Q_REQ]                       = req_ff[n];
        w[`CFT_Q_AUTO]                      = auto_ff[n];
        w[`CFT_Q_PRIO_LSB+1:`CFT_Q_PRIO_LSB] = prio_ff[n];
        return w;
    endfunction : queue_word

    assign rd_take = hsel && htrans[1] && hready && !hwrite;
    assign rd_kind = decode(haddr[11:0]);
    assign rd_idx  = haddr[6:2];
    assign wr_kind = decode(wr_addr_ff);
    assign wr_idx  = wr_addr_ff[6:2];

    always_comb begin
        for (int f = 0; f < NF; f++) begin
            flt_en[f]            = flt_ff[f/4][(f%4)*`CFT_LANE_W + `CFT_LANE_EN];
            mask_choice[2*f +: 2] = flt_ff[f/4][(f%4)*`CFT_LANE_W + `CFT_LANE_MSEL_LSB +: 2];
        end
    end
    assign filter_on_flag = flt_en;
    assign live_hit       = rx_hit & flt_en;

    // Bus slave: zero wait, read data captured in the address phase
    always_comb begin
        nxt_wr_pend = hsel && htrans[1] && hready && hwrite;
        nxt_wr_addr = nxt_wr_pend ? haddr[11:0] : wr_addr_ff;
        nxt_hrdata  = 32'h0000_0000;
        if (rd_take) begin
            case (rd_kind)
                CFT_K_MODE: nxt_hrdata[`CFT_MODE_LSB +: 3] = mode_ff;
                CFT_K_STAT: nxt_hrdata[`CFT_IRQ_W-1:0] = stat_ff;
                CFT_K_MASK: nxt_hrdata[`CFT_IRQ_W-1:0] = mask_ff;
                CFT_K_FLT:  nxt_hrdata = flt_ff[rd_idx[2:0]];
                CFT_K_FIFO: nxt_hrdata = queue_word(int'(rd_idx));
                default:    nxt_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // Filter words, mode and interrupt registers
    always_comb begin
        nxt_mode = mode_ff;
        nxt_mask = mask_ff;
        for (int r = 0; r < NUM_FLT_REGS; r++) begin
            nxt_flt[r] = flt_ff[r];
        end
        if (wr_pend_ff) begin
            case (wr_kind)
                CFT_K_MODE: nxt_mode = hwdata[`CFT_MODE_LSB +: 3];
                CFT_K_MASK: nxt_mask = hwdata[`CFT_IRQ_W-1:0];
                CFT_K_FLT: begin
                    for (int l = 0; l < 4; l++) begin
                        nxt_flt[wr_idx[2:0]][l*`CFT_LANE_W + `CFT_LANE_EN] =
                            hwdata[l*`CFT_LANE_W + `CFT_LANE_EN];
                        if (!flt_ff[wr_idx[2:0]][l*`CFT_LANE_W + `CFT_LANE_EN]) begin
                            nxt_flt[wr_idx[2:0]][l*`CFT_LANE_W +: 7] =
                                hwdata[l*`CFT_LANE_W +: 7];
                        end
                    end
                end
                default: nxt_mode = mode_ff;
            endcase
        end
        // Read clears, a new event in the same cycle survives
        nxt_stat = (rd_take && rd_kind == CFT_K_STAT) ? '0 : stat_ff;
        nxt_stat[`CFT_IRQ_RX_STORE] |= rx_valid && (live_hit != '0);
        nxt_stat[`CFT_IRQ_RX_DROP]  |= rx_valid && (live_hit == '0);
        nxt_stat[`CFT_IRQ_TX_SENT]  |= evt_sent && evt_last;
        nxt_stat[`CFT_IRQ_TX_ABORT] |= evt_aborted;
        nxt_stat[`CFT_IRQ_ARB]      |= evt_arb_lost;
        nxt_stat[`CFT_IRQ_FAULT]    |= evt_bus_err;
        nxt_irq = (nxt_stat & nxt_mask) != '0;
    end

    // Per-queue control state
    always_comb begin
        nxt_req     = req_ff;
        nxt_abort   = abort_ff;
        nxt_abandon = abandon_ff;
        nxt_arb     = arb_ff;
        nxt_fault   = fault_ff;
        nxt_auto    = auto_ff;
        nxt_dir     = dir_ff;
        for (int n = 0; n < NQ; n++) begin
            nxt_prio[n] = prio_ff[n];
            if (queue_reset && evt_queue == 5'(n)) begin
                nxt_req[n]     = 1'b0;
                nxt_abort[n]   = 1'b0;
                nxt_abandon[n] = 1'b0;
                nxt_arb[n]     = 1'b0;
                nxt_fault[n]   = 1'b0;
            end else begin
                if (rd_take && rd_kind == CFT_K_FIFO && rd_idx == 5'(n)) begin
                    nxt_arb[n]   = 1'b0;
                    nxt_fault[n] = 1'b0;
                end
                if (wr_pend_ff && wr_kind == CFT_K_FIFO && wr_idx == 5'(n)) begin
                    if (mode_ff == `CFT_MODE_CONFIG) begin
                        nxt_dir[n]  = hwdata[`CFT_Q_DIR];
                        nxt_auto[n] = hwdata[`CFT_Q_AUTO];
                        nxt_prio[n] = hwdata[`CFT_Q_PRIO_LSB +: 2];
                    end
                    if (dir_ff[n]) begin
                        if (hwdata[`CFT_Q_REQ]) begin
                            nxt_req[n] = 1'b1;
                        end else if (req_ff[n]) begin
                            nxt_abort[n] = 1'b1;
                        end
                    end
                end
                nxt_req[n] |= rtr_rx && rtr_queue == 5'(n) && auto_ff[n] && dir_ff[n];
                if (evt_queue == 5'(n)) begin
                    if (evt_sent) begin
                        nxt_abandon[n] = 1'b0;
                        if (evt_last) begin
                            nxt_req[n]   = 1'b0;
                            nxt_abort[n] = 1'b0;
                        end
                    end
                    if (evt_aborted) begin
                        nxt_abandon[n] = 1'b1;
                        nxt_req[n]     = 1'b0;
                        nxt_abort[n]   = 1'b0;
                    end
                    nxt_arb[n]   |= evt_arb_lost;
                    nxt_fault[n] |= evt_bus_err;
                end
            end
        end
    end

    // Offer selection and receive routing
    always_comb begin
        logic [1:0] best_prio;
        best_prio      = 2'b00;
        nxt_tx_pending = 1'b0;
        nxt_tx_queue   = 5'h00;
        for (int n = 0; n < NQ; n++) begin
            if (req_ff[n] && dir_ff[n] && (!nxt_tx_pending || prio_ff[n] > best_prio)) begin
                nxt_tx_pending = 1'b1;
                nxt_tx_queue   = 5'(n);
                best_prio      = prio_ff[n];
            end
        end
        nxt_tx_abort = nxt_tx_pending && abort_ff[nxt_tx_queue];
        nxt_rx_store = rx_valid && (live_hit != '0);
        nxt_rx_drop  = rx_valid && (live_hit == '0);
        nxt_rx_queue = rx_queue_ff;
        nxt_rx_mask  = rx_mask_ff;
        if (nxt_rx_store) begin
            nxt_rx_queue = flt_ff[lowest_index(live_hit) / 4][(lowest_index(live_hit) % 4)
                               * `CFT_LANE_W + `CFT_LANE_DEST_LSB +: 5];
            nxt_rx_mask  = mask_choice[2*lowest_index(live_hit) +: 2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flt_ff        <= '{default: `CFT_FLT_RST};
            prio_ff       <= '{default: 2'b00};
            req_ff        <= '0;
            abort_ff      <= '0;
            abandon_ff    <= '0;
            arb_ff        <= '0;
            fault_ff      <= '0;
            auto_ff       <= '0;
            dir_ff        <= '0;
            mode_ff       <= `CFT_MODE_RST;
            stat_ff       <= '0;
            mask_ff       <= '0;
            irq_ff        <= 1'b0;
            wr_pend_ff    <= 1'b0;
            wr_addr_ff    <= 12'h000;
            hrdata_ff     <= 32'h0000_0000;
            hreadyout_ff  <= 1'b1;
            rx_store_ff   <= 1'b0;
            rx_drop_ff    <= 1'b0;
            rx_queue_ff   <= 5'h00;
            rx_mask_ff    <= 2'b00;
            tx_pending_ff <= 1'b0;
            tx_queue_ff   <= 5'h00;
            tx_abort_ff   <= 1'b0;
        end else begin
            flt_ff        <= nxt_flt;
            prio_ff       <= nxt_prio;
            req_ff        <= nxt_req;
            abort_ff      <= nxt_abort;
            abandon_ff    <= nxt_abandon;
            arb_ff        <= nxt_arb;
            fault_ff      <= nxt_fault;
            auto_ff       <= nxt_auto;
            dir_ff        <= nxt_dir;
            mode_ff       <= nxt_mode;
            stat_ff       <= nxt_stat;
            mask_ff       <= nxt_mask;
            irq_ff        <= nxt_irq;
            wr_pend_ff    <= nxt_wr_pend;
            wr_addr_ff    <= nxt_wr_addr;
            hrdata_ff     <= nxt_hrdata;
            hreadyout_ff  <= 1'b1;
            rx_store_ff   <= nxt_rx_store;
            rx_drop_ff    <= nxt_rx_drop;
            rx_queue_ff   <= nxt_rx_queue;
            rx_mask_ff    <= nxt_rx_mask;
            tx_pending_ff <= nxt_tx_pending;
            tx_queue_ff   <= nxt_tx_queue;
            tx_abort_ff   <= nxt_tx_abort;
        end
    end

    assign hrdata               = hrdata_ff;
    assign hreadyout            = hreadyout_ff;
    assign hresp                = 1'b0;
    assign rx_store             = rx_store_ff;
    assign rx_drop              = rx_drop_ff;
    assign rx_queue             = rx_queue_ff;
    assign rx_mask              = rx_mask_ff;
    assign tx_pending           = tx_pending_ff;
    assign tx_queue             = tx_queue_ff;
    assign tx_abort             = tx_abort_ff;
    assign operating_mode_field = mode_ff;
    assign irq                  = irq_ff;
    // Checks on queue 0, filter 0 and receive drop routing
    logic q0_wr, q0_evt, f0_wr;
    assign q0_wr  = wr_pend_ff && wr_kind == CFT_K_FIFO && wr_idx == 5'h00;
    assign q0_evt = evt_queue == 5'h00 && (evt_sent || evt_aborted || queue_reset);
    assign f0_wr  = wr_pend_ff && wr_kind == CFT_K_FLT && wr_idx == 5'h00;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_filter_lock: assert property (f0_wr && flt_ff[0][7] |=> $stable(flt_ff[0][6:0]))
        else $error("filter fields changed while enabled");
    a_done_clears: assert property (evt_sent && evt_last && evt_queue == 5'h00 && !queue_reset
        |=> !req_ff[0])
        else $error("send request not cleared after last message");
    a_abort_asks: assert property (q0_wr && dir_ff[0] && req_ff[0] && !hwdata[3] && !q0_evt
        |=> abort_ff[0] ##1 abort_ff[0] || !req_ff[0])
        else $error("clearing send request did not ask for abort");
    a_rx_ignores: assert property (q0_wr && !dir_ff[0] && !q0_evt && !(rtr_rx && auto_ff[0])
        |=> req_ff[0] == $past(req_ff[0]))
        else $error("receive queue reacted to send request");
    a_remote_sets: assert property (rtr_rx && rtr_queue == 5'h00 && auto_ff[0] && dir_ff[0]
        && !q0_evt |=> req_ff[0] ##1 tx_pending_ff)
        else $error("remote request did not set send request");
    a_abandon_mark: assert property (evt_aborted && evt_queue == 5'h00 && !queue_reset
        |=> abandon_ff[0] && !req_ff[0])
        else $error("abort not recorded");
    a_arb_sets: assert property (evt_arb_lost && evt_queue == 5'h00 && !queue_reset
        |=> arb_ff[0] ##1 arb_ff[0] || $past(rd_take) || $past(queue_reset))
        else $error("arbitration loss not recorded");
    a_fault_sets: assert property (evt_bus_err && evt_queue == 5'h00 && !queue_reset
        |=> fault_ff[0])
        else $error("bus error not recorded");
    a_read_clears: assert property (rd_take && rd_kind == CFT_K_FIFO && rd_idx == 5'h00
        && !(evt_queue == 5'h00 && (evt_arb_lost || evt_bus_err)) |=> !arb_ff[0] && !fault_ff[0])
        else $error("read did not clear loss and fault flags");
    a_mode_lock: assert property (q0_wr && mode_ff != `CFT_MODE_CONFIG
        |=> $stable(dir_ff[0]) && $stable(prio_ff[0]))
        else $error("configuration changed outside configuration mode");
    a_offer_valid: assert property (tx_pending_ff |-> $past(req_ff[0]) || tx_queue_ff != 5'h00)
        else $error("offered queue had no request");
    a_route_drop: assert property (rx_valid && live_hit == '0 |=> rx_drop_ff && !rx_store_ff)
        else $error("unmatched message not dropped");
endmodule : cft_filter_tx_ctrl

// ==== core/cft_pkg.sv ====
// Types shared by the filter and send control block
package cft_pkg;
    typedef enum logic [2:0] {
        CFT_K_NONE,
        CFT_K_MODE,
        CFT_K_STAT,
        CFT_K_MASK,
        CFT_K_FLT,
        CFT_K_FIFO
    } cft_reg_kind_type;
endpackage : cft_pkg

// ==== test/cft_bus_node_model.sv ====
// Far-side model: other bus nodes and the message engine events
module cft_bus_node_model (
    input  wire logic        hclk,
    output logic             rx_valid,
    output logic [31:0]      rx_hit,
    output logic             rtr_rx,
    output logic [4:0]       rtr_queue,
    output logic [4:0]       evt_queue,
    output logic             evt_sent,
    output logic             evt_last,
    output logic             evt_aborted,
    output logic             evt_arb_lost,
    output logic             evt_bus_err,
    output logic             queue_reset
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {rx_valid, rtr_rx, evt_sent, evt_last, evt_aborted} = 5'h00;
        {evt_arb_lost, evt_bus_err, queue_reset} = 3'h0;
        {rx_hit, rtr_queue, evt_queue} = 42'h0;
    end

    // One-cycle event of kind k for queue q
    task fire(input int k, input logic [4:0] q, input logic [31:0] hit);
        @(posedge hclk);
        evt_queue <= q;
        rtr_queue <= q;
        rx_hit    <= hit;
        case (k)
            0: rx_valid <= 1'b1;
            1: rtr_rx <= 1'b1;
            2: {evt_sent, evt_last} <= 2'b11;
            3: evt_aborted <= 1'b1;
            4: evt_arb_lost <= 1'b1;
            default: evt_bus_err <= 1'b1;
        endcase
        @(posedge hclk);
        {rx_valid, rtr_rx, evt_sent, evt_last, evt_aborted} <= 5'h00;
        {evt_arb_lost, evt_bus_err} <= 2'h0;
    endtask : fire
endmodule : cft_bus_node_model

// ==== test/cft_filter_tx_ctrl_tb.sv ====
// Self-checking bench for the filter and send control block
module cft_filter_tx_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic        rx_valid, rtr_rx, evt_sent, evt_last, evt_aborted, queue_reset;
    logic        evt_arb_lost, evt_bus_err, rx_store, rx_drop, tx_pending, tx_abort;
    logic [31:0] haddr, hwdata, hrdata, rx_hit, filter_on_flag;
    logic [1:0]  htrans, rx_mask;
    logic [2:0]  hsize, operating_mode_field;
    logic [4:0]  rtr_queue, evt_queue, rx_queue, tx_queue;
    logic [63:0] mask_choice;
    int          err_total, num_checks;

    assign hready = hreadyout;

    cft_filter_tx_ctrl #(.NUM_FLT_REGS(8), .NUM_QUEUES(32)) i_cft_filter_tx_ctrl (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .rx_valid, .rx_hit, .rtr_rx, .rtr_queue,
        .evt_queue, .evt_sent, .evt_last, .evt_aborted, .evt_arb_lost, .evt_bus_err,
        .queue_reset, .rx_store, .rx_drop, .rx_queue, .rx_mask, .filter_on_flag,
        .mask_choice, .tx_pending, .tx_queue, .tx_abort, .operating_mode_field, .irq
    );

    cft_bus_node_model i_cft_bus_node_model (
        .hclk, .rx_valid, .rx_hit, .rtr_rx, .rtr_queue, .evt_queue, .evt_sent,
        .evt_last, .evt_aborted, .evt_arb_lost, .evt_bus_err, .queue_reset
    );

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // One single AHB-Lite transfer, address phase then data phase
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {20'h0_0000, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask : bus

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    task rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0000_0000, r);
        chk(r, exp);
    endtask : rd

    task settle;
        repeat (3) @(negedge hclk);
    endtask : settle

    task fire(input int k, input logic [4:0] q, input logic [31:0] hit);
        i_cft_bus_node_model.fire(k, q, hit);
        settle;
    endtask : fire

    task t_reset;
        rd(12'h000, 32'h0080_0000);
        rd(12'h040, 32'h0000_0000);
        rd(12'h0FC, 32'h0000_0000);
        rd(12'h100, 32'h0000_0000);
        chk({27'h0, hresp, hreadyout, operating_mode_field}, 32'h0000_000C);
        $display("test reset done");
    endtask : t_reset

    task t_filter;
        wr(12'h040, 32'h0000_63A7);
        rd(12'h040, 32'h0000_63A7);
        chk({30'h0, filter_on_flag[1:0]}, 32'h0000_0001);
        chk({30'h0, mask_choice[1:0]}, 32'h0000_0001);
        wr(12'h040, 32'h0000_63DF);
        rd(12'h040, 32'h0000_63A7);
        i_cft_bus_node_model.fire(0, 5'h00, 32'h0000_0003);
        @(negedge hclk);
        chk({24'h0, rx_store, rx_mask, rx_queue}, 32'h0000_00A7);
        i_cft_bus_node_model.fire(0, 5'h00, 32'h0000_0002);
        @(negedge hclk);
        chk({30'h0, rx_drop, rx_store}, 32'h0000_0002);
        $display("test filter done");
    endtask : t_filter

    task t_send;
        wr(12'h080, 32'h0000_008D);
        wr(12'h094, 32'h0000_008B);
        rd(12'h080, 32'h0000_0085);
        wr(12'h080, 32'h0000_008D);
        wr(12'h094, 32'h0000_008B);
        wr(12'h08C, 32'h0000_0008);
        rd(12'h08C, 32'h0000_0000);
        settle;
        chk({26'h0, tx_pending, tx_queue}, 32'h0000_0025);
        fire(2, 5'd5, 32'h0);
        rd(12'h094, 32'h0000_0083);
        chk({26'h0, tx_pending, tx_queue}, 32'h0000_0020);
        wr(12'h080, 32'h0000_0085);
        settle;
        chk({31'h0, tx_abort}, 32'h0000_0001);
        rd(12'h080, 32'h0000_008D);
        fire(3, 5'd0, 32'h0);
        rd(12'h080, 32'h0000_00C5);
        chk({31'h0, tx_pending}, 32'h0000_0000);
        $display("test send done");
    endtask : t_send

    task t_flags;
        wr(12'h008, 32'h0000_0010);
        rd(12'h004, 32'h0000_000F);
        fire(5, 5'd0, 32'h0);
        chk({31'h0, irq}, 32'h0000_0000);
        fire(4, 5'd0, 32'h0);
        chk({31'h0, irq}, 32'h0000_0001);
        rd(12'h080, 32'h0000_00F5);
        rd(12'h080, 32'h0000_00C5);
        rd(12'h004, 32'h0000_0030);
        settle;
        chk({31'h0, irq}, 32'h0000_0000);
        $display("test flags done");
    endtask : t_flags

    task t_mode;
        wr(12'h000, 32'h0000_0000);
        wr(12'h080, 32'h0000_0003);
        rd(12'h080, 32'h0000_00C5);
        chk({29'h0, operating_mode_field}, 32'h0000_0000);
        fire(1, 5'd0, 32'h0);
        rd(12'h080, 32'h0000_00CD);
        chk({26'h0, tx_pending, tx_queue}, 32'h0000_0020);
        fire(2, 5'd0, 32'h0);
        chk({31'h0, tx_pending}, 32'h0000_0000);
        $display("test mode done");
    endtask : t_mode

    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    initial begin
        repeat (5000) @(posedge hclk);
        err_total++;
        print_verdict;
    end

    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = 69'h0;
        hsize      = 3'b010;
        err_total  = 0;
        num_checks = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_filter;
        t_send;
        t_flags;
        t_mode;
        print_verdict;
    end
endmodule : cft_filter_tx_ctrl_tb
